// ==== pkg/intr_router_pkg.sv ====
// package: sizes, source codes, trigger modes and carrier structs of the interrupt router
`default_nettype none
package intr_router_pkg;
    // ******************************
    // sizes
    // ******************************
    localparam int NUM_EXT = 12;          // external inputs 0..11
    localparam int NUM_CHAIN = 8;         // chain shared lines
    localparam int NUM_TIMER = 8;         // counter-timer pulse sources
    localparam int NUM_SWP = 4;           // software pulse sources
    localparam int NUM_OUT = 4;           // external output lines
    localparam int NUM_SRC = NUM_EXT + NUM_CHAIN; // sources with arm/enable logic
    localparam int VEC_W = 5;             // vector width, covers NUM_SRC
    localparam int SEL_W = 6;             // line driver select width

    // ******************************
    // line driver select codes
    // ******************************
    localparam logic [SEL_W-1:0] SEL_NONE = 6'h00;
    localparam logic [SEL_W-1:0] SEL_EXT_BASE = 6'h01;   // 0x01..0x0c
    localparam logic [SEL_W-1:0] SEL_TIMER_BASE = 6'h0d; // 0x0d..0x14
    localparam logic [SEL_W-1:0] SEL_SWP_BASE = 6'h15;   // 0x15..0x18
    localparam logic [SEL_W-1:0] SEL_CHAIN_BASE = 6'h19; // 0x19..0x20, output lines only

    // ******************************
    // reset values
    // ******************************
    localparam logic [NUM_SRC-1:0] ARM_RESET = 20'h00000;
    localparam logic [NUM_SRC-1:0] EN_RESET = 20'h00000;
    localparam logic [VEC_W-1:0] VEC_RESET = 5'h00;

    // trigger modes of an external input
    typedef enum logic [1:0] {
        TRIG_FALLING = 2'h0, // default
        TRIG_RISING = 2'h1,
        TRIG_HIGH = 2'h3,
        TRIG_LOW = 2'h2
    } trig_mode_e;

    // host control strobes, one bit per source, one-cycle pulses
    typedef struct packed {
        logic [NUM_SRC-1:0] arm_set;
        logic [NUM_SRC-1:0] arm_clr;
        logic [NUM_SRC-1:0] en_set;
        logic [NUM_SRC-1:0] en_clr;
        logic [NUM_SRC-1:0] pend_clr;
    } host_ctl_s;

    // per-source state shown to the host
    typedef struct packed {
        logic [NUM_SRC-1:0] armed;
        logic [NUM_SRC-1:0] enabled;
        logic [NUM_SRC-1:0] request;
        logic [NUM_SRC-1:0] pending;
    } src_status_s;
endpackage
`default_nettype wire

// ==== hdl/intr_router.sv ====
// interrupt router: recognition, arm/enable, pending, priority and line routing
// Operation
// - after reset every source is disarmed and disabled
// - host arms, disarms, enables, disables each source on its own
// - delivery happens only when the source is armed and enabled
// - each recognized request of an armed source sets its request bit
// - disarm clears the request bit; requests while disarmed are dropped
// - requests of enabled sources enter priority resolution
// - disabled armed sources hold requests and deliver once enabled
// - next instance waits until the host clears the pending bit
// - processed interrupt goes to host only; routed chain lines carry the raw source
// - edge mode needs deassert then reassert for another request
// - inputs may be level sensitive, high or low
// - external input drives its chain line raw, bypassing local logic
// - software request hits only the local source, not the chain line
// - any source may drive an external output line
// - local chain signal gives two interrupts with separate vectors
// - chain lines start disarmed and then raise no local interrupt
// - twelve external inputs numbered 0 to 11
// - rising, falling, high or low trigger; falling is the default
`timescale 1ns/1ns
`default_nettype none
module intr_router (
    input wire logic core_clk_in,
    input wire logic sys_rst_in,
    input wire logic [intr_router_pkg::NUM_EXT-1:0] ext_irq_in,
    input wire logic [intr_router_pkg::NUM_CHAIN-1:0] chain_shared_line_in,
    input wire logic [intr_router_pkg::NUM_TIMER-1:0] timer_pulse_in,
    input wire logic [intr_router_pkg::NUM_SWP-1:0] software_pulse_source_in,
    input wire logic [intr_router_pkg::NUM_EXT-1:0] sw_request_in,
    input wire logic [2*intr_router_pkg::NUM_EXT-1:0] ext_mode_in,
    input wire intr_router_pkg::host_ctl_s host_ctl_in,
    input wire logic [intr_router_pkg::NUM_CHAIN*intr_router_pkg::SEL_W-1:0] chain_sel_in,
    input wire logic [intr_router_pkg::NUM_OUT*intr_router_pkg::SEL_W-1:0] out_sel_in,
    output logic irq_out,
    output logic [intr_router_pkg::VEC_W-1:0] vector_out,
    output logic [intr_router_pkg::NUM_CHAIN-1:0] chain_shared_line_out,
    output logic [intr_router_pkg::NUM_OUT-1:0] ext_line_out,
    output intr_router_pkg::src_status_s status_out
);
    import intr_router_pkg::*;

    // ******************************
    // input synchronisers
    // ******************************
    // external, chain, timer and software pulse pins are asynchronous; stage one feeds stage two only
    logic [NUM_EXT-1:0] ext_s1;
    logic [NUM_EXT-1:0] ext_s2;
    logic [NUM_EXT-1:0] ext_prev;
    logic [NUM_CHAIN-1:0] chain_s1;
    logic [NUM_CHAIN-1:0] chain_s2;
    logic [NUM_CHAIN-1:0] chain_prev;
    logic [NUM_TIMER-1:0] timer_s1;
    logic [NUM_TIMER-1:0] timer_s2;
    logic [NUM_SWP-1:0] swp_s1;
    logic [NUM_SWP-1:0] swp_s2;
    logic [NUM_SRC-1:0] hit;
    logic [NUM_CHAIN-1:0] chain_view;
    logic [NUM_CHAIN-1:0] chain_drive;

    // external inputs rest high, the idle level of the default falling-edge mode
    always_ff @(posedge core_clk_in) begin
        if (sys_rst_in) begin
            ext_s1 <= '1;
            ext_s2 <= '1;
        end else begin
            ext_s1 <= ext_irq_in;
            ext_s2 <= ext_s1;
        end
    end

    // incoming chain lines idle low between pulses
    always_ff @(posedge core_clk_in) begin
        if (sys_rst_in) begin
            chain_s1 <= '0;
            chain_s2 <= '0;
        end else begin
            chain_s1 <= chain_shared_line_in;
            chain_s2 <= chain_s1;
        end
    end

    // timer sources are only routed, never recognised here
    always_ff @(posedge core_clk_in) begin
        if (sys_rst_in) begin
            timer_s1 <= '0;
            timer_s2 <= '0;
        end else begin
            timer_s1 <= timer_pulse_in;
            timer_s2 <= timer_s1;
        end
    end

    // software pulse sources are only routed as well
    always_ff @(posedge core_clk_in) begin
        if (sys_rst_in) begin
            swp_s1 <= '0;
            swp_s2 <= '0;
        end else begin
            swp_s1 <= software_pulse_source_in;
            swp_s2 <= swp_s1;
        end
    end

    // ******************************
    // edge history
    // ******************************
    // ext history starts high like its synchroniser, so no false edge follows reset;
    // a high-level input reads asserted for two cycles; a source armed on the first takes a request on the second
    always_ff @(posedge core_clk_in) begin
        if (sys_rst_in) begin
            ext_prev <= '1;
        end else begin
            ext_prev <= ext_s2;
        end
    end

    // chain history follows what the local recogniser sees, own drive included
    always_ff @(posedge core_clk_in) begin
        if (sys_rst_in) begin
            chain_prev <= '0;
        end else begin
            chain_prev <= chain_view;
        end
    end

    // ******************************
    // request recognition
    // ******************************
    // a locally driven chain line is seen locally too, giving its own vector
    assign chain_view = chain_s2 | chain_shared_line_out;

    genvar gi;
    generate
        for (gi = 0; gi < NUM_EXT; gi++) begin : g_ext_recog
            trig_mode_e mode;
            logic rec;
            assign mode = trig_mode_e'(ext_mode_in[2*gi +: 2]);
            // edge modes fire once per transition, so the input must go back
            // to its idle level before another request can be raised
            always_comb begin
                case (mode)
                    TRIG_RISING: rec = ext_s2[gi] & ~ext_prev[gi];
                    TRIG_FALLING: rec = ~ext_s2[gi] & ext_prev[gi];
                    TRIG_HIGH: rec = ext_s2[gi];
                    TRIG_LOW: rec = ~ext_s2[gi];
                    default: rec = 1'b0;
                endcase
            end
            // software request only reaches the local source bit
            assign hit[gi] = rec | sw_request_in[gi];
        end
        for (gi = 0; gi < NUM_CHAIN; gi++) begin : g_chain_recog
            // chain lines carry pulses; recognise their rising edge
            assign hit[NUM_EXT+gi] = chain_view[gi] & ~chain_prev[gi];
        end
    endgenerate

    // ******************************
    // arm, enable, request and pending per source
    // ******************************
    logic [NUM_SRC-1:0] armed;
    logic [NUM_SRC-1:0] enabled;
    logic [NUM_SRC-1:0] request;
    logic [NUM_SRC-1:0] pending;
    logic [NUM_SRC-1:0] take;

    generate
        for (gi = 0; gi < NUM_SRC; gi++) begin : g_src
            // a request moves to pending only when enabled and not already pending
            assign take[gi] = request[gi] & enabled[gi] & ~pending[gi];

            // arm bit; a simultaneous disarm beats arm
            always_ff @(posedge core_clk_in) begin
                if (sys_rst_in) begin
                    armed[gi] <= ARM_RESET[gi];
                end else if (host_ctl_in.arm_clr[gi]) begin
                    armed[gi] <= 1'b0;
                end else if (host_ctl_in.arm_set[gi]) begin
                    armed[gi] <= 1'b1;
                end
            end

            // enable bit; a simultaneous disable beats enable
            always_ff @(posedge core_clk_in) begin
                if (sys_rst_in) begin
                    enabled[gi] <= EN_RESET[gi];
                end else if (host_ctl_in.en_clr[gi]) begin
                    enabled[gi] <= 1'b0;
                end else if (host_ctl_in.en_set[gi]) begin
                    enabled[gi] <= 1'b1;
                end
            end

            // request bit: held while disabled, merged while pending
            always_ff @(posedge core_clk_in) begin
                if (sys_rst_in) begin
                    request[gi] <= 1'b0;
                end else if (!armed[gi] || host_ctl_in.arm_clr[gi]) begin
                    request[gi] <= 1'b0;
                end else if (hit[gi]) begin
                    request[gi] <= 1'b1;
                end else if (take[gi]) begin
                    request[gi] <= 1'b0;
                end
            end

            // pending bit; set cannot meet clear since set needs pending low
            always_ff @(posedge core_clk_in) begin
                if (sys_rst_in) begin
                    pending[gi] <= 1'b0;
                end else if (take[gi]) begin
                    pending[gi] <= 1'b1;
                end else if (host_ctl_in.pend_clr[gi]) begin
                    pending[gi] <= 1'b0;
                end
            end
        end
    endgenerate

    // ******************************
    // priority resolution and host delivery
    // ******************************
    // lowest source index wins; vector equals source index
    // a fixed order keeps the vector steady while several sources wait
    logic [VEC_W-1:0] next_vector;
    logic next_irq;

    always_comb begin
        next_vector = VEC_RESET;
        next_irq = 1'b0;
        for (int i = NUM_SRC - 1; i >= 0; i--) begin
            if (pending[i]) begin
                next_vector = VEC_W'(i);
                next_irq = 1'b1;
            end
        end
    end

    // level held while any delivered interrupt awaits its handler
    always_ff @(posedge core_clk_in) begin
        if (sys_rst_in) begin
            irq_out <= 1'b0;
        end else begin
            irq_out <= next_irq;
        end
    end

    // vector registered alongside the level so both change on one edge
    always_ff @(posedge core_clk_in) begin
        if (sys_rst_in) begin
            vector_out <= VEC_RESET;
        end else begin
            vector_out <= next_vector;
        end
    end

    // ******************************
    // line routing
    // ******************************
    // pick one signal from the raw sources by select code
    function automatic logic pick(input logic [SEL_W-1:0] sel, input logic [NUM_EXT-1:0] ext,
                                  input logic [NUM_TIMER-1:0] tmr, input logic [NUM_SWP-1:0] swp,
                                  input logic [NUM_CHAIN-1:0] chn, input logic chain_ok);
        logic v;
        v = 1'b0;
        for (int k = 0; k < NUM_EXT; k++) begin
            if (sel == SEL_EXT_BASE + SEL_W'(k)) begin
                v = ext[k];
            end
        end
        for (int k = 0; k < NUM_TIMER; k++) begin
            if (sel == SEL_TIMER_BASE + SEL_W'(k)) begin
                v = tmr[k];
            end
        end
        for (int k = 0; k < NUM_SWP; k++) begin
            if (sel == SEL_SWP_BASE + SEL_W'(k)) begin
                v = swp[k];
            end
        end
        for (int k = 0; k < NUM_CHAIN; k++) begin
            if (chain_ok && sel == SEL_CHAIN_BASE + SEL_W'(k)) begin
                v = chn[k];
            end
        end
        return v;
    endfunction

    // one driver per line is the host's duty; a line never selects itself
    generate
        for (gi = 0; gi < NUM_CHAIN; gi++) begin : g_chain_drv
            // raw synchronised input drives the line, not the armed request
            assign chain_drive[gi] = pick(
                chain_sel_in[gi*SEL_W +: SEL_W],
                ext_s2,
                timer_s2,
                swp_s2,
                chain_s2,
                1'b0 // a chain line never repeats an incoming chain line
            );
        end
    endgenerate

    always_ff @(posedge core_clk_in) begin
        if (sys_rst_in) begin
            chain_shared_line_out <= '0;
        end else begin
            chain_shared_line_out <= chain_drive;
        end
    end

    // output lines may take any source, including incoming chain lines
    generate
        for (gi = 0; gi < NUM_OUT; gi++) begin : g_out_drv
            always_ff @(posedge core_clk_in) begin
                if (sys_rst_in) begin
                    ext_line_out[gi] <= 1'b0;
                end else begin
                    ext_line_out[gi] <= pick(
                        out_sel_in[gi*SEL_W +: SEL_W],
                        ext_s2,
                        timer_s2,
                        swp_s2,
                        chain_s2,
                        1'b1
                    );
                end
            end
        end
    endgenerate

    // ******************************
    // status to host
    // ******************************
    // status bits come straight from the flops above, no shadow copy to drift
    assign status_out.armed = armed;
    assign status_out.enabled = enabled;
    assign status_out.request = request;
    assign status_out.pending = pending;
endmodule // intr_router
`default_nettype wire

// ==== sim/host_handler_model.sv ====
// host handler model: waits, services the delivered vector and clears its pending bit
`timescale 1ns/1ns
`default_nettype none
module host_handler_model #(
    parameter int LAT = 4
) (
    input wire logic core_clk_in,
    input wire logic sys_rst_in,
    input wire logic irq_in,
    input wire logic [intr_router_pkg::VEC_W-1:0] vector_in,
    output logic [intr_router_pkg::NUM_SRC-1:0] pend_clr_out,
    output logic [15:0] served_out,
    output logic [intr_router_pkg::VEC_W-1:0] last_vec_out
);
    import intr_router_pkg::*;
    int w;
    // service after LAT cycles; the tail skips the irq level that lags the clear
    always @(negedge core_clk_in) begin
        pend_clr_out <= '0;
        if (sys_rst_in) begin
            w <= 0;
            served_out <= 16'h0000;
            last_vec_out <= 5'h00;
        end else if (w == 0) begin
            if (irq_in) w <= LAT + 3;
        end else begin
            w <= w - 1;
            if (w == 4) begin
                pend_clr_out <= NUM_SRC'(1) << vector_in;
                served_out <= served_out + 16'h0001;
                last_vec_out <= vector_in;
            end
        end
    end
endmodule // host_handler_model
`default_nettype wire

// ==== sim/intr_router_assertions.sv ====
// checker: arm, enable, pending and delivery relations of the interrupt router
`timescale 1ns/1ns
`default_nettype none
module intr_router_assertions (
    input wire logic core_clk_in,
    input wire logic sys_rst_in,
    input wire intr_router_pkg::host_ctl_s host_ctl_in,
    input wire logic irq_out,
    input wire logic [intr_router_pkg::VEC_W-1:0] vector_out,
    input wire intr_router_pkg::src_status_s status_out
);
    import intr_router_pkg::*;
    logic [NUM_SRC-1:0] arm_on, en_on, pnd, ae;
    logic any_p;
    // clear beats set, so only uncontested sets are expected to land
    assign arm_on = host_ctl_in.arm_set & ~host_ctl_in.arm_clr;
    assign en_on = host_ctl_in.en_set & ~host_ctl_in.en_clr;
    assign pnd = status_out.pending;
    assign ae = status_out.armed & status_out.enabled;
    assign any_p = |pnd;
    function automatic logic [VEC_W-1:0] lowest(input logic [NUM_SRC-1:0] p);
        lowest = 5'h00;
        for (int i = NUM_SRC - 1; i >= 0; i--) begin
            if (p[i]) lowest = VEC_W'(i);
        end
    endfunction
    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (sys_rst_in);
    property p_reset; $past(sys_rst_in) |-> status_out == 80'h0 && !irq_out; endproperty
    a_reset: assert property (p_reset) else $error("state not clear after reset");
    property p_arm; arm_on != '0 |=> (status_out.armed & $past(arm_on)) == $past(arm_on); endproperty
    a_arm: assert property (p_arm) else $error("arm did not land");
    property p_en; en_on != '0 |=> (status_out.enabled & $past(en_on)) == $past(en_on); endproperty
    a_en: assert property (p_en) else $error("enable did not land");
    property p_disarm;
        host_ctl_in.arm_clr != '0 |=> ((status_out.armed | status_out.request) & $past(host_ctl_in.arm_clr)) == '0;
    endproperty
    a_disarm: assert property (p_disarm) else $error("disarm left armed or request");
    property p_req; (status_out.request & ~status_out.armed) == '0; endproperty
    a_req: assert property (p_req) else $error("request on disarmed source");
    property p_take; (pnd & ~$past(pnd) & ~$past(ae)) == '0; endproperty
    a_take: assert property (p_take) else $error("pending set without arm and enable");
    property p_hold; ($past(pnd) & ~$past(host_ctl_in.pend_clr) & ~pnd) == '0; endproperty
    a_hold: assert property (p_hold) else $error("pending dropped without host clear");
    property p_irq; irq_out == $past(any_p); endproperty
    a_irq: assert property (p_irq) else $error("irq does not follow pending");
    property p_vec; irq_out |-> vector_out == lowest($past(pnd)); endproperty
    a_vec: assert property (p_vec) else $error("vector not lowest pending");
endmodule // intr_router_assertions
bind intr_router intr_router_assertions u_chk (.core_clk_in(core_clk_in), .sys_rst_in(sys_rst_in),
    .host_ctl_in(host_ctl_in), .irq_out(irq_out), .vector_out(vector_out), .status_out(status_out));
`default_nettype wire

// ==== sim/arm_enable_interrupt_router_tb_top.sv ====
// testbench: drives sources and host strobes, checks delivery and routing
`timescale 1ns/1ns
`default_nettype none
module arm_enable_interrupt_router_tb_top;
    import intr_router_pkg::*;
    logic clk = 1'b0, rst = 1'b1;
    logic [11:0] ext = 12'hfff, swr = 12'h000;
    logic [7:0] chin = 8'h00, tmr = 8'h00, chout;
    logic [3:0] swp = 4'h0, xout;
    logic [23:0] mode = 24'h0, osel = 24'h0;
    logic [47:0] csel = 48'h0;
    logic [19:0] arm_s = '0, arm_c = '0, en_s = '0, en_c = '0, pclr;
    logic irq;
    logic [4:0] vec, lastv;
    logic [15:0] served;
    src_status_s st;
    int fail_count = 0, checked = 0, b, d;
    always #20 clk = ~clk;
    intr_router u_dut (.core_clk_in(clk), .sys_rst_in(rst), .ext_irq_in(ext), .chain_shared_line_in(chin),
        .timer_pulse_in(tmr), .software_pulse_source_in(swp), .sw_request_in(swr), .ext_mode_in(mode),
        .host_ctl_in({arm_s, arm_c, en_s, en_c, pclr}), .chain_sel_in(csel), .out_sel_in(osel), .irq_out(irq),
        .vector_out(vec), .chain_shared_line_out(chout), .ext_line_out(xout), .status_out(st));
    host_handler_model #(.LAT(4)) u_host (.core_clk_in(clk), .sys_rst_in(rst), .irq_in(irq), .vector_in(vec),
        .pend_clr_out(pclr), .served_out(served), .last_vec_out(lastv));
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    task automatic chk(input logic [79:0] got, input logic [79:0] exp);
        checked++;
        if (got !== exp) begin
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
            fail_count++;
        end
    endtask
    task automatic idle(input int n);
        repeat (n) @(negedge clk);
    endtask
    // one-cycle host strobes; a free cycle before keeps drivers from double assigning
    task automatic ctl(input logic [19:0] a, input logic [19:0] ac, input logic [19:0] e, input logic [19:0] ec);
        @(negedge clk);
        {arm_s, arm_c, en_s, en_c} = {a, ac, e, ec};
        @(negedge clk);
        {arm_s, arm_c, en_s, en_c} = '0;
    endtask
    task automatic wait_more(input int base);
        int n;
        n = 0;
        while (served == base && n < 300) begin
            @(negedge clk);
            n++;
        end
        if (served == base) begin
            fail_count++;
            wrap_up();
        end
    endtask
    initial begin
        trig_mode_e modes[4] = '{TRIG_RISING, TRIG_HIGH, TRIG_LOW, TRIG_FALLING};
        repeat (10) @(negedge clk);
        rst = 1'b0;
        idle(1);
        chk(st, 80'h0);
        chk({irq, vec, chout, xout}, 80'h0);
        ctl(20'h00001, '0, 20'h00001, '0);
        chk(st.armed & st.enabled, 20'h00001);
        b = served;
        ext[0] = 1'b0;
        wait_more(b);
        chk(lastv, 5'h00);
        idle(30);
        chk(served, 16'(b + 1));
        ext[0] = 1'b1;
        idle(30);
        chk(served, 16'(b + 1));
        ext[0] = 1'b0;
        wait_more(b + 1);
        $display("edge test done");
        idle(10);
        b = served;
        ext[1] = 1'b0;
        idle(20);
        chk({served, st.request}, {16'(b), 20'h0});
        // disabled source: two hits merge into one held request
        ctl(20'h00004, '0, '0, '0);
        ext[2] = 1'b0;
        idle(10);
        ext[2] = 1'b1;
        idle(10);
        ext[2] = 1'b0;
        idle(10);
        chk({st.request, st.pending}, {20'h00004, 20'h0});
        ctl('0, '0, 20'h00004, '0);
        wait_more(b);
        idle(30);
        chk({served, lastv}, {16'(b + 1), 5'h02});
        ctl(20'h00008, '0, '0, '0);
        ext[3] = 1'b0;
        idle(10);
        chk(st.request, 20'h00008);
        ctl('0, 20'h00008, '0, '0);
        chk(st.request, 20'h0);
        $display("arm enable test done");
        for (int i = 4; i < 8; i++) begin
            mode[2*i+:2] = modes[i-4];
            ctl(20'h00001 << i, '0, 20'h00001 << i, '0);
            b = served;
            ext[i] = 1'b0;
            idle(40);
            ext[i] = 1'b1;
            idle(40);
            d = served - b;
            chk(modes[i-4][1] ? d >= 2 : d == 1, 1'b1);
            ctl('0, 20'h00001 << i, '0, 20'h00001 << i);
            idle(20);
        end
        $display("mode test done");
        csel[5:0] = 6'h09;
        idle(5);
        chk(chout[0], 1'b1);
        ctl(20'h01100, '0, 20'h01100, '0);
        b = served;
        swr[8] = 1'b1;
        idle(1);
        swr[8] = 1'b0;
        wait_more(b);
        chk(lastv, 5'h08);
        idle(20);
        chk({served, chout[0]}, {16'(b + 1), 1'b1});
        b = served;
        ext[8] = 1'b0;
        wait_more(b);
        chk({lastv, chout[0]}, {5'h08, 1'b0});
        b = served;
        ext[8] = 1'b1;
        wait_more(b);
        chk(lastv, 5'h0c);
        $display("chain test done");
        osel = {6'h0a, 6'h1c, 6'h16, 6'h0f};
        ctl(20'h08000, '0, 20'h08000, '0);
        b = served;
        {tmr[2], swp[1], chin[4:3], ext[9]} = 5'h1e;
        wait_more(b);
        chk(lastv, 5'h0f);
        idle(20);
        chk({served, xout}, {16'(b + 1), 4'h7});
        {tmr[2], swp[1], chin[4:3], ext[9]} = 5'h01;
        idle(6);
        chk(xout, 4'h8);
        $display("routing test done");
        wrap_up();
    end
endmodule // arm_enable_interrupt_router_tb_top
`default_nettype wire
